/* File: hw/canopen_pkg.sv */
/*
  Constants, encodings and the NMT state type of the CAN slave node.
  Assumes a frame-level CAN controller beside it on the same clock.
*/
`default_nettype none

package canopen_pkg;

  typedef enum logic [3:0] {
    ST_INIT  = 4'h1,
    ST_PREOP = 4'h2,
    ST_OP    = 4'h4,
    ST_STOP  = 4'h8
  } nmt_state_e;

  localparam logic [10:0] ID_NMT         = 11'h000;
  localparam logic [10:0] ID_EMCY_BASE   = 11'h080;
  localparam logic [10:0] ID_PDO_BASE    = 11'h180;
  localparam logic [10:0] ID_SDO_TX_BASE = 11'h580;
  localparam logic [10:0] ID_SDO_RX_BASE = 11'h600;
  localparam logic [10:0] ID_GUARD_BASE  = 11'h700;
  localparam logic [10:0] ID_LSS_TX      = 11'h7e4;
  localparam logic [10:0] ID_LSS_RX      = 11'h7e5;
  localparam logic [3:0]  DLC_FULL       = 4'h8;
  localparam logic [3:0]  DLC_NMT        = 4'h2;
  localparam logic [3:0]  DLC_GUARD      = 4'h1;

  localparam logic [7:0] NMT_START      = 8'h01;
  localparam logic [7:0] NMT_STOP       = 8'h02;
  localparam logic [7:0] NMT_PREOP      = 8'h80;
  localparam logic [7:0] NMT_RESET_NODE = 8'h81;
  localparam logic [7:0] NMT_RESET_COMM = 8'h82;

  localparam logic [6:0] GUARD_BOOT  = 7'h00;
  localparam logic [6:0] GUARD_STOP  = 7'h04;
  localparam logic [6:0] GUARD_OP    = 7'h05;
  localparam logic [6:0] GUARD_PREOP = 7'h7f;

  localparam logic [6:0] NODE_ID_DFLT = 7'h06;
  localparam logic [3:0] RATE_1000 = 4'h0;
  localparam logic [3:0] RATE_800  = 4'h1;
  localparam logic [3:0] RATE_500  = 4'h2;
  localparam logic [3:0] RATE_250  = 4'h3;
  localparam logic [3:0] RATE_125  = 4'h4;
  localparam logic [3:0] RATE_50   = 4'h6;
  localparam logic [3:0] RATE_20   = 4'h7;
  localparam logic [3:0] RATE_10   = 4'h8;
  localparam logic [3:0] RATE_DFLT = RATE_125;

  localparam logic [7:0] SDO_READ      = 8'h40;
  localparam logic [7:0] SDO_READ_RSP  = 8'h43;
  localparam logic [7:0] SDO_WRITE_RSP = 8'h60;
  localparam logic [7:0] SDO_ABORT     = 8'h80;
  localparam logic [31:0] ABT_BAD_CMD  = 32'h0504_0001;
  localparam logic [31:0] ABT_RO       = 32'h0601_0002;
  localparam logic [31:0] ABT_NO_OBJ   = 32'h0602_0000;
  localparam logic [31:0] ABT_NO_SUB   = 32'h0609_0011;

  localparam logic [15:0] OBJ_DEVICE_TYPE = 16'h1000;
  localparam logic [15:0] OBJ_ERROR_REG   = 16'h1001;
  localparam logic [15:0] OBJ_IDENTITY    = 16'h1018;
  localparam logic [15:0] OBJ_SYS_STATUS  = 16'h2211;
  localparam logic [15:0] OBJ_CONTROL     = 16'h2214;
  localparam logic [7:0]  IDENT_SUBS      = 8'h04;

  localparam logic [7:0] LSS_SW_GLOBAL = 8'h04;
  localparam logic [7:0] LSS_SEL_VEND  = 8'h40;
  localparam logic [7:0] LSS_SEL_PROD  = 8'h41;
  localparam logic [7:0] LSS_SEL_REV   = 8'h42;
  localparam logic [7:0] LSS_SEL_SER   = 8'h43;
  localparam logic [7:0] LSS_SEL_ACK   = 8'h44;
  localparam logic [7:0] LSS_CFG_ID    = 8'h11;
  localparam logic [7:0] LSS_CFG_RATE  = 8'h13;
  localparam logic [7:0] LSS_STORE     = 8'h17;
  localparam logic [7:0] LSS_ERR       = 8'h01;

  localparam logic [3:0] REG_NODE   = 4'h0;
  localparam logic [3:0] REG_RATE   = 4'h1;
  localparam logic [3:0] REG_STATUS = 4'h2;
  localparam logic [3:0] REG_CTRL   = 4'h3;

  localparam logic [1:0] SETTLE_CYCLES = 2'h3;

  function automatic logic rate_ok(input logic [3:0] r);
    rate_ok = (r <= RATE_10) && (r != 4'h5);
  endfunction

endpackage

`default_nettype wire

/* File: hw/sdo_frame_codec.sv */
/*
  Splits an SDO request payload into fields and builds a response payload.
  Assumes byte 0 of a frame sits in data bits 7:0.
*/
`default_nettype none

module sdo_frame_codec (
  input  wire logic [63:0] rq_frame_i,
  output logic      [7:0]  rq_cmd_o,
  output logic      [15:0] rq_index_o,
  output logic      [7:0]  rq_sub_o,
  output logic      [31:0] rq_value_o,
  input  wire logic [7:0]  rs_cmd_i,
  input  wire logic [15:0] rs_index_i,
  input  wire logic [7:0]  rs_sub_i,
  input  wire logic [31:0] rs_value_i,
  output logic      [63:0] rs_frame_o
);

  // Command, index low, index high, subindex, value LSB first
  assign rq_cmd_o   = rq_frame_i[7:0];
  assign rq_index_o = {rq_frame_i[23:16], rq_frame_i[15:8]};
  assign rq_sub_o   = rq_frame_i[31:24];
  assign rq_value_o = rq_frame_i[63:32];
  assign rs_frame_o = {rs_value_i, rs_sub_i, rs_index_i, rs_cmd_i};

endmodule

`default_nettype wire

/* File: hw/canopen_node.sv */
/*
  CAN slave node: NMT state machine, node-ID and bit-rate selection,
  LSS slave, SDO server, node guarding and PDO/EMCY gating.
  Assumes a frame-level CAN controller on ref_clk_i and raw DIP pins.
*/
`default_nettype none

module canopen_node
  import canopen_pkg::*;
#(
  parameter logic [31:0] DEVICE_TYPE = 32'h0000_0000, // Arbitrary
  parameter logic [31:0] VENDOR_ID   = 32'h0000_1234, // Arbitrary
  parameter logic [31:0] PRODUCT_ID  = 32'h0000_5678, // Arbitrary
  parameter logic [31:0] REVISION    = 32'h0000_0001, // Arbitrary
  parameter logic [31:0] SERIAL_NO   = 32'h0000_0042  // Arbitrary
) (
  input  wire logic        ref_clk_i,
  input  wire logic        resetn_i,
  input  wire logic [7:0]  dip_sw_i,
  input  wire logic        rx_valid_i,
  input  wire logic [10:0] rx_id_i,
  input  wire logic        rx_rtr_i,
  input  wire logic [3:0]  rx_dlc_i,
  input  wire logic [63:0] rx_data_i,
  output logic             rx_ready_o,
  output logic             tx_valid_o,
  output logic      [10:0] tx_id_o,
  output logic      [3:0]  tx_dlc_o,
  output logic      [63:0] tx_data_o,
  input  wire logic        tx_ready_i,
  input  wire logic        pdo_valid_i,
  input  wire logic [63:0] pdo_data_i,
  output logic             pdo_ack_o,
  input  wire logic        emcy_valid_i,
  input  wire logic [63:0] emcy_data_i,
  output logic             emcy_ack_o,
  input  wire logic [15:0] app_status_i,
  input  wire logic [3:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_we_i,
  input  wire logic        reg_re_i,
  output logic      [31:0] reg_rdata_o,
  output logic      [6:0]  node_id_o,
  output logic      [3:0]  bit_rate_o,
  output nmt_state_e       nmt_state_o,
  output logic      [7:0]  control_o
);

  logic [7:0]  dip_meta_q;
  logic [7:0]  dip_sw_q;
  logic [1:0]  settle_q;
  logic        rate_done_q;
  logic [6:0]  stored_id_q;
  logic [3:0]  stored_rate_q;
  logic        lss_cfg_q;
  logic [1:0]  lss_step_q;
  logic        toggle_q;
  logic [6:0]  sel_id;
  logic [3:0]  sel_rate;
  logic        settled;
  logic        rx_take;
  logic        dip_off;
  logic        is_nmt, is_guard, is_sdo, is_lss;
  logic        tx_ld, boot_ld, nmt_go, guard_go, ctrl_we;
  logic [10:0] ld_id;
  logic [3:0]  ld_dlc;
  logic [63:0] ld_data;
  logic        lss_id_we, lss_rate_we, lss_cfg_d_we, lss_cfg_d;
  logic        lss_step_we;
  logic [1:0]  lss_step_d;
  logic [7:0]  lss_err;
  logic [7:0]  rq_cmd, rq_sub, rs_cmd;
  logic [15:0] rq_index;
  logic [31:0] rq_value, rs_value, obj_val;
  logic [63:0] rs_frame;
  logic        obj_ok, obj_ro, sub_ok;
  logic [6:0]  guard_code;
  logic        tx_free;
  logic        pdo_ack_d, emcy_ack_d;
  logic        tx_valid_d;

  // Pins are asynchronous to ref_clk_i
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dip_meta_q <= 8'h00;
      dip_sw_q   <= 8'h00;
    end else begin
      dip_meta_q <= dip_sw_i;
      dip_sw_q   <= dip_meta_q;
    end
  end

  assign settled = (settle_q == SETTLE_CYCLES);
  assign dip_off = (dip_sw_q == 8'h00);
  assign rx_take = rx_valid_i && rx_ready_o;

  always_comb begin
    sel_id = (dip_sw_q[5:0] != 6'h00) ? {1'b0, dip_sw_q[5:0]}
                                      : stored_id_q;
    case (dip_sw_q[7:6])
      2'b10:   sel_rate = RATE_250;
      2'b01:   sel_rate = RATE_500;
      2'b11:   sel_rate = RATE_1000;
      default: sel_rate = stored_rate_q;
    endcase
  end

  // Bit rate is caught once after power-up, never on NMT resets
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      settle_q    <= 2'h0;
      rate_done_q <= 1'b0;
      bit_rate_o  <= RATE_DFLT;
    end else begin
      if (!settled) begin
        settle_q <= settle_q + 2'h1;
      end
      if (settled && !rate_done_q) begin
        rate_done_q <= 1'b1;
        bit_rate_o  <= sel_rate;
      end
    end
  end

  sdo_frame_codec u_codec (
    .rq_frame_i (rx_data_i),
    .rq_cmd_o   (rq_cmd),
    .rq_index_o (rq_index),
    .rq_sub_o   (rq_sub),
    .rq_value_o (rq_value),
    .rs_cmd_i   (rs_cmd),
    .rs_index_i (rq_index),
    .rs_sub_i   (rq_sub),
    .rs_value_i (rs_value),
    .rs_frame_o (rs_frame)
  );

  // Object lookup and SDO response
  always_comb begin
    obj_ok  = 1'b1;
    obj_ro  = 1'b1;
    sub_ok  = (rq_sub == 8'h00);
    obj_val = 32'h0;
    case (rq_index)
      OBJ_DEVICE_TYPE: obj_val = DEVICE_TYPE;
      OBJ_ERROR_REG:   obj_val = 32'h0;
      OBJ_IDENTITY: begin
        sub_ok = (rq_sub <= IDENT_SUBS);
        case (rq_sub)
          8'h00:   obj_val = {24'h0, IDENT_SUBS};
          8'h01:   obj_val = VENDOR_ID;
          8'h02:   obj_val = PRODUCT_ID;
          8'h03:   obj_val = REVISION;
          8'h04:   obj_val = SERIAL_NO;
          default: obj_val = 32'h0;
        endcase
      end
      OBJ_SYS_STATUS: obj_val = {16'h0, app_status_i};
      OBJ_CONTROL: begin
        obj_ro  = 1'b0;
        obj_val = {24'h0, control_o};
      end
      default: obj_ok = 1'b0;
    endcase
    rs_cmd   = SDO_ABORT;
    rs_value = ABT_BAD_CMD;
    ctrl_we  = 1'b0;
    if (!obj_ok) begin
      rs_value = ABT_NO_OBJ;
    end else if (!sub_ok) begin
      rs_value = ABT_NO_SUB;
    end else if (rq_cmd == SDO_READ) begin
      rs_cmd   = SDO_READ_RSP;
      rs_value = obj_val;
    end else if (rq_cmd[7:5] == 3'b001 && rq_cmd[1]) begin
      if (obj_ro) begin
        rs_value = ABT_RO;
      end else begin
        rs_cmd   = SDO_WRITE_RSP;
        rs_value = 32'h0;
        ctrl_we  = rx_take && is_sdo;
      end
    end
  end

  always_comb begin
    case (nmt_state_o)
      ST_STOP: guard_code = GUARD_STOP;
      ST_OP:   guard_code = GUARD_OP;
      default: guard_code = GUARD_PREOP;
    endcase
  end

  // Frame classes; SDO and LSS need all eight bytes
  always_comb begin
    is_nmt   = (rx_id_i == ID_NMT) && !rx_rtr_i && (rx_dlc_i == DLC_NMT)
            && (nmt_state_o != ST_INIT)
            && (rx_data_i[15:8] == 8'h00
                || rx_data_i[15:8] == {1'b0, node_id_o});
    is_guard = rx_rtr_i && (nmt_state_o != ST_INIT)
            && (rx_id_i == ID_GUARD_BASE + {4'h0, node_id_o});
    is_sdo   = !rx_rtr_i && (rx_dlc_i == DLC_FULL)
            && (rx_id_i == ID_SDO_RX_BASE + {4'h0, node_id_o})
            && (nmt_state_o == ST_PREOP || nmt_state_o == ST_OP);
    is_lss   = !rx_rtr_i && (rx_dlc_i == DLC_FULL)
            && (rx_id_i == ID_LSS_RX) && dip_off;
  end

  // Transmit source selection and LSS decode
  always_comb begin
    tx_ld        = 1'b0;
    boot_ld      = 1'b0;
    nmt_go       = 1'b0;
    guard_go     = 1'b0;
    pdo_ack_d    = 1'b0;
    emcy_ack_d   = 1'b0;
    ld_id        = ID_GUARD_BASE;
    ld_dlc       = DLC_FULL;
    ld_data      = 64'h0;
    lss_id_we    = 1'b0;
    lss_rate_we  = 1'b0;
    lss_cfg_d_we = 1'b0;
    lss_cfg_d    = 1'b0;
    lss_step_we  = 1'b0;
    lss_step_d   = 2'h0;
    lss_err      = 8'h00;
    if (rx_take) begin
      if (is_nmt) begin
        nmt_go = 1'b1;
      end else if (is_guard) begin
        guard_go = 1'b1;
        tx_ld    = 1'b1;
        ld_id    = ID_GUARD_BASE + {4'h0, node_id_o};
        ld_dlc   = DLC_GUARD;
        ld_data  = {56'h0, toggle_q, guard_code};
      end else if (is_sdo) begin
        tx_ld   = 1'b1;
        ld_id   = ID_SDO_TX_BASE + {4'h0, node_id_o};
        ld_data = rs_frame;
      end else if (is_lss) begin
        ld_id       = ID_LSS_TX;
        lss_step_we = 1'b1;
        case (rx_data_i[7:0])
          LSS_SW_GLOBAL: begin
            lss_cfg_d_we = 1'b1;
            lss_cfg_d    = rx_data_i[8];
          end
          LSS_SEL_VEND:
            lss_step_d = (rx_data_i[39:8] == VENDOR_ID) ? 2'h1 : 2'h0;
          LSS_SEL_PROD:
            lss_step_d = (lss_step_q == 2'h1
                       && rx_data_i[39:8] == PRODUCT_ID) ? 2'h2 : 2'h0;
          LSS_SEL_REV:
            lss_step_d = (lss_step_q == 2'h2
                       && rx_data_i[39:8] == REVISION) ? 2'h3 : 2'h0;
          LSS_SEL_SER: begin
            if (lss_step_q == 2'h3 && rx_data_i[39:8] == SERIAL_NO) begin
              lss_cfg_d_we = 1'b1;
              lss_cfg_d    = 1'b1;
              tx_ld        = 1'b1;
              ld_data      = {56'h0, LSS_SEL_ACK};
            end
          end
          LSS_CFG_ID: begin
            tx_ld = lss_cfg_q;
            if (rx_data_i[15:8] == 8'h00 || rx_data_i[15]) begin
              lss_err = LSS_ERR;
            end else begin
              lss_id_we = lss_cfg_q;
            end
            ld_data = {48'h0, lss_err, LSS_CFG_ID};
          end
          LSS_CFG_RATE: begin
            tx_ld = lss_cfg_q;
            if (rx_data_i[15:8] != 8'h00 || rx_data_i[23:20] != 4'h0
                || !rate_ok(rx_data_i[19:16])) begin
              lss_err = LSS_ERR;
            end else begin
              lss_rate_we = lss_cfg_q;
            end
            ld_data = {48'h0, lss_err, LSS_CFG_RATE};
          end
          // Values are kept at once, so store only confirms
          LSS_STORE: begin
            tx_ld   = lss_cfg_q;
            ld_data = {56'h0, LSS_STORE};
          end
          // Activate-bit-timing is ignored: rate waits for power-up
          default: lss_step_d = lss_step_q;
        endcase
      end
    end else if (tx_free && nmt_state_o == ST_INIT && rate_done_q) begin
      boot_ld = 1'b1;
      tx_ld   = 1'b1;
      ld_id   = ID_GUARD_BASE + {4'h0, sel_id};
      ld_dlc  = DLC_GUARD;
      ld_data = {57'h0, GUARD_BOOT};
    end else if (tx_free && nmt_state_o == ST_OP && emcy_valid_i) begin
      emcy_ack_d = 1'b1;
      tx_ld      = 1'b1;
      ld_id      = ID_EMCY_BASE + {4'h0, node_id_o};
      ld_data    = emcy_data_i;
    end else if (tx_free && nmt_state_o == ST_OP && pdo_valid_i) begin
      pdo_ack_d = 1'b1;
      tx_ld     = 1'b1;
      ld_id     = ID_PDO_BASE + {4'h0, node_id_o};
      ld_data   = pdo_data_i;
    end
  end

  assign tx_free    = !tx_valid_o;
  assign tx_valid_d = tx_ld || (tx_valid_o && !tx_ready_i);

  // One frame held; receive stalls while it waits
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tx_valid_o <= 1'b0;
      rx_ready_o <= 1'b1;
      tx_id_o    <= 11'h000;
      tx_dlc_o   <= 4'h0;
      tx_data_o  <= 64'h0;
      pdo_ack_o  <= 1'b0;
      emcy_ack_o <= 1'b0;
    end else begin
      tx_valid_o <= tx_valid_d;
      rx_ready_o <= !tx_valid_d;
      pdo_ack_o  <= pdo_ack_d;
      emcy_ack_o <= emcy_ack_d;
      if (tx_ld) begin
        tx_id_o   <= ld_id;
        tx_dlc_o  <= ld_dlc;
        tx_data_o <= ld_data;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      nmt_state_o <= ST_INIT;
      node_id_o   <= NODE_ID_DFLT;
      toggle_q    <= 1'b0;
    end else begin
      if (guard_go) begin
        toggle_q <= !toggle_q;
      end
      case (nmt_state_o)
        ST_INIT: begin
          if (boot_ld) begin
            nmt_state_o <= ST_PREOP;
            node_id_o   <= sel_id;
            toggle_q    <= 1'b0;
          end
        end
        ST_PREOP, ST_OP, ST_STOP: begin
          if (nmt_go) begin
            case (rx_data_i[7:0])
              NMT_START:      nmt_state_o <= ST_OP;
              NMT_STOP:       nmt_state_o <= ST_STOP;
              NMT_PREOP:      nmt_state_o <= ST_PREOP;
              NMT_RESET_NODE: nmt_state_o <= ST_INIT;
              NMT_RESET_COMM: nmt_state_o <= ST_INIT;
              default:        nmt_state_o <= nmt_state_o;
            endcase
          end
        end
        default: nmt_state_o <= ST_INIT;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      control_o <= 8'h00;
    end else if (nmt_go && rx_data_i[7:0] == NMT_RESET_NODE) begin
      control_o <= 8'h00;
    end else if (ctrl_we) begin
      control_o <= rq_value[7:0];
    end
  end

  // Software write wins over an LSS write in the same cycle
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      stored_id_q   <= NODE_ID_DFLT;
      stored_rate_q <= RATE_DFLT;
      lss_cfg_q     <= 1'b0;
      lss_step_q    <= 2'h0;
    end else begin
      if (reg_we_i && reg_addr_i == REG_NODE
          && reg_wdata_i[6:0] != 7'h00) begin
        stored_id_q <= reg_wdata_i[6:0];
      end else if (lss_id_we) begin
        stored_id_q <= rx_data_i[14:8];
      end
      if (reg_we_i && reg_addr_i == REG_RATE
          && reg_wdata_i[31:4] == 28'h0 && rate_ok(reg_wdata_i[3:0])) begin
        stored_rate_q <= reg_wdata_i[3:0];
      end else if (lss_rate_we) begin
        stored_rate_q <= rx_data_i[19:16];
      end
      if (lss_cfg_d_we) begin
        lss_cfg_q <= lss_cfg_d;
      end
      if (lss_step_we) begin
        lss_step_q <= lss_step_d;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reg_rdata_o <= 32'h0;
    end else if (reg_re_i) begin
      case (reg_addr_i)
        REG_NODE:   reg_rdata_o <= {25'h0, stored_id_q};
        REG_RATE:   reg_rdata_o <= {28'h0, stored_rate_q};
        REG_STATUS: reg_rdata_o <= {16'h0, nmt_state_o, bit_rate_o,
                                    1'b0, node_id_o};
        REG_CTRL:   reg_rdata_o <= {24'h0, control_o};
        default:    reg_rdata_o <= 32'h0;
      endcase
    end else begin
      reg_rdata_o <= 32'h0;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);

  sequence sdo_req;
    rx_valid_i && rx_ready_o && is_sdo;
  endsequence
  sequence sdo_read_req;
    sdo_req ##0 rq_cmd == SDO_READ;
  endsequence

  chk_init_to_preop: assert property (
    $past(nmt_state_o) == ST_INIT && nmt_state_o != ST_INIT
    |-> nmt_state_o == ST_PREOP) else $error("init left to wrong state");
  chk_pdo_gate: assert property (
    $rose(tx_valid_o) && (tx_id_o[10:7] == 4'h3 || tx_id_o[10:7] == 4'h1)
    |-> $past(nmt_state_o) == ST_OP) else $error("pdo or emcy not in op");
  chk_stop_quiet: assert property (
    $rose(tx_valid_o) && $past(nmt_state_o) == ST_STOP
    |-> tx_id_o == ID_GUARD_BASE + {4'h0, node_id_o}
        || tx_id_o == ID_LSS_TX) // Replies to the master only
    else $error("traffic while stopped");
  chk_node_range: assert property (
    node_id_o != 7'h00 && stored_id_q != 7'h00)
    else $error("node id zero");
  chk_rate_hold: assert property (
    $past(rate_done_q) |-> $stable(bit_rate_o))
    else $error("bit rate changed after power-up");
  chk_id_pick: assert property (
    boot_ld && dip_sw_q[5:0] == 6'h00 |=> node_id_o == $past(stored_id_q))
    else $error("stored id not used");
  chk_sdo_answer: assert property (
    sdo_req |=> tx_valid_o && tx_dlc_o == DLC_FULL
             && tx_id_o == ID_SDO_TX_BASE + {4'h0, node_id_o})
    else $error("sdo request not answered");
  chk_read_reply: assert property (
    sdo_read_req |=> tx_data_o[7:0] == SDO_READ_RSP
                  || tx_data_o[7:0] == SDO_ABORT)
    else $error("read reply command wrong");
  chk_lss_gate: assert property (
    $rose(tx_valid_o) && tx_id_o == ID_LSS_TX
    |-> $past(dip_sw_q) == 8'h00 && tx_dlc_o == DLC_FULL)
    else $error("lss served with switches set");

endmodule

`default_nettype wire

/* File: verif/can_master_model.sv */
/*
  Master-side CAN controller model: takes every frame the node sends.
  Assumes one clock shared with canopen_node.
*/
`default_nettype none
module can_master_model (
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire logic        slow_i,
  input  wire logic        tx_valid_i,
  input  wire logic [10:0] tx_id_i,
  input  wire logic [63:0] tx_data_i,
  output logic             tx_ready_o,
  output logic             got_o,
  output logic      [10:0] got_id_o,
  output logic      [63:0] got_data_o
);
  logic [1:0] wait_q;
  // Slow mode stalls each frame so the node must hold it
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tx_ready_o <= 1'b0;
      wait_q     <= 2'h0;
      got_o      <= 1'b0;
    end else begin
      got_o      <= tx_valid_i & tx_ready_o;
      wait_q     <= (tx_valid_i & !tx_ready_o) ? wait_q + 2'h1 : 2'h0;
      tx_ready_o <= tx_valid_i & !tx_ready_o & (!slow_i | wait_q == 2'h3);
    end
  end
  always_ff @(posedge clk_i) begin
    if (tx_valid_i & tx_ready_o) begin
      got_id_o   <= tx_id_i;
      got_data_o <= tx_data_i;
    end
  end
endmodule
`default_nettype wire

/* File: verif/canopen_node_test.sv */
/*
  Bench for canopen_node: NMT, SDO, guard, LSS, switches, registers.
  Assumes can_master_model answers the node's transmit side.
*/
`default_nettype none
module canopen_node_test;
  import canopen_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] VEND = 32'h0000_abcd; // Arbitrary
  logic        clk = 1'b0, rstn = 1'b0, slow = 1'b0, rv = 1'b0, rtr = 1'b0;
  logic        pv = 1'b0, we = 1'b0, re = 1'b0;
  logic [7:0]  dip = 8'h00;
  logic [10:0] rid = 11'h000;
  logic [3:0]  dlc = 4'h0, ra = 4'h0;
  logic [63:0] rd = 64'h0;
  logic [31:0] wd = 32'h0;
  logic        rdy, txv, txr, pack, got;
  logic [10:0] txid, gid;
  logic [3:0]  txn, rate;
  logic [63:0] txd, gd;
  logic [31:0] rdata;
  logic [6:0]  nid;
  logic [7:0]  ctl;
  nmt_state_e  st;
  int          fails = 0, num_checks = 0, cyc = 0, acks = 0;
  always #20 clk = ~clk;
  canopen_node #(.VENDOR_ID(VEND)) dut (.ref_clk_i(clk), .resetn_i(rstn),
    .dip_sw_i(dip), .rx_valid_i(rv), .rx_id_i(rid), .rx_rtr_i(rtr),
    .rx_dlc_i(dlc), .rx_data_i(rd), .rx_ready_o(rdy), .tx_valid_o(txv),
    .tx_id_o(txid), .tx_dlc_o(txn), .tx_data_o(txd), .tx_ready_i(txr),
    .pdo_valid_i(pv), .pdo_data_i(64'h1122_3344_5566_7788), .pdo_ack_o(pack),
    .emcy_valid_i(1'b0), .emcy_data_i(64'h0), .emcy_ack_o(),
    .app_status_i(16'h0008), .reg_addr_i(ra), .reg_wdata_i(wd),
    .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdata), .node_id_o(nid),
    .bit_rate_o(rate), .nmt_state_o(st), .control_o(ctl));
  can_master_model far (.clk_i(clk), .resetn_i(rstn), .slow_i(slow),
    .tx_valid_i(txv), .tx_id_i(txid), .tx_data_i(txd), .tx_ready_o(txr),
    .got_o(got), .got_id_o(gid), .got_data_o(gd));
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(string what, logic [63:0] seen, logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  always @(posedge clk) begin
    cyc++;
    acks += (pack === 1'b1);
    if (cyc == 20000) begin
      fails++;
      stop_test();
    end
  end
  task automatic send(logic [10:0] i, logic r, logic [3:0] n, logic [63:0] d);
    rv <= 1'b1;
    rid <= i;
    rtr <= r;
    dlc <= n;
    rd <= d;
    do @(posedge clk); while (rdy !== 1'b1);
    rv <= 1'b0;
    // One idle edge so a following send never re-drives rv in this step
    @(posedge clk);
  endtask
  task automatic expect_tx(string what, logic [10:0] i, logic [63:0] d);
    int k;
    k = 0;
    do begin @(posedge clk); k++; end while (got !== 1'b1 && k < 40);
    check(what, {53'h0, gid}, {53'h0, i});
    check(what, gd, d);
  endtask
  task automatic reg_rd(string what, logic [3:0] a, logic [31:0] e);
    re <= 1'b1;
    ra <= a;
    @(posedge clk);
    re <= 1'b0;
    @(posedge clk);
    check(what, {32'h0, rdata}, {32'h0, e});
  endtask
  task automatic quiet(string what);
    int n;
    n = 0;
    repeat (30) begin @(posedge clk); n += (got === 1'b1); end
    check(what, 64'(n), 64'h0);
  endtask
  task automatic power(logic [6:0] id);
    rstn <= 1'b0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    expect_tx("bootup", ID_GUARD_BASE + 11'(id), 64'h0);
    check("state", {60'h0, st}, {60'h0, ST_PREOP});
    check("node id", {57'h0, nid}, {57'h0, id});
    check("boot dlc", {60'h0, txn}, {60'h0, DLC_GUARD});
  endtask
  initial begin
    static logic [7:0] sw [3] = '{8'h80, 8'h40, 8'hc0};
    static logic [3:0] rt [3] = '{RATE_250, RATE_500, RATE_1000};
    power(7'h06);
    check("rate", {60'h0, rate}, {60'h0, RATE_DFLT});
    send(ID_SDO_RX_BASE + 11'h6, 1'b0, DLC_FULL,
      {32'h0, 8'h01, 16'h1018, SDO_READ});
    expect_tx("sdo", ID_SDO_TX_BASE + 11'h6,
      {VEND, 8'h01, 16'h1018, SDO_READ_RSP});
    slow <= 1'b1;
    send(ID_SDO_RX_BASE + 11'h6, 1'b0, DLC_FULL,
      {32'h0, 8'h00, 16'h3000, SDO_READ});
    expect_tx("abort", ID_SDO_TX_BASE + 11'h6,
      {ABT_NO_OBJ, 8'h00, 16'h3000, SDO_ABORT});
    $display("sdo test done");
    pv <= 1'b1;
    repeat (20) @(posedge clk);
    check("preop acks", 64'(acks), 64'h0);
    send(ID_NMT, 1'b0, DLC_NMT, {48'h0, 8'h06, NMT_START});
    do @(posedge clk); while (pack !== 1'b1 && cyc < 19000);
    pv <= 1'b0;
    expect_tx("pdo", ID_PDO_BASE + 11'h6, 64'h1122_3344_5566_7788);
    send(ID_SDO_RX_BASE + 11'h6, 1'b0, DLC_FULL,
      {32'h5a, 8'h00, 16'h2214, 8'h23});
    expect_tx("write", ID_SDO_TX_BASE + 11'h6,
      {32'h0, 8'h00, 16'h2214, SDO_WRITE_RSP});
    check("control", {56'h0, ctl}, 64'h5a);
    send(ID_NMT, 1'b0, DLC_NMT, {48'h0, 8'h00, NMT_STOP});
    send(ID_GUARD_BASE + 11'h6, 1'b1, 4'h0, 64'h0);
    expect_tx("guard", ID_GUARD_BASE + 11'h6, {57'h0, GUARD_STOP});
    $display("nmt test done");
    slow <= 1'b0;
    send(ID_LSS_RX, 1'b0, DLC_FULL, {48'h0, 8'h01, LSS_SW_GLOBAL});
    send(ID_LSS_RX, 1'b0, DLC_FULL, {48'h0, 8'h0a, LSS_CFG_ID});
    expect_tx("lss", ID_LSS_TX, {56'h0, LSS_CFG_ID});
    reg_rd("stored id", REG_NODE, 32'h0a);
    send(ID_NMT, 1'b0, DLC_NMT, {48'h0, 8'h00, NMT_RESET_NODE});
    expect_tx("new id", ID_GUARD_BASE + 11'h0a, 64'h0);
    check("control clear", {56'h0, ctl}, 64'h0);
    we <= 1'b1;
    ra <= REG_NODE;
    wd <= 32'h0;
    @(posedge clk);
    ra <= REG_RATE;
    wd <= {28'h0, RATE_500};
    @(posedge clk);
    we <= 1'b0;
    reg_rd("id zero", REG_NODE, 32'h0a);
    reg_rd("rate", REG_RATE, {28'h0, RATE_500});
    reg_rd("unmapped", 4'hf, 32'h0);
    reg_rd("status", REG_STATUS,
      {16'h0, ST_PREOP, RATE_DFLT, 1'b0, 7'h0a});
    $display("lss test done");
    dip <= 8'hc3;
    // Switch pins pass a two-stage synchroniser first
    repeat (3) @(posedge clk);
    send(ID_LSS_RX, 1'b0, DLC_FULL, {48'h0, 8'h0b, LSS_CFG_ID});
    quiet("lss off");
    send(ID_NMT, 1'b0, DLC_NMT, {48'h0, 8'h0a, NMT_RESET_NODE});
    expect_tx("switch id", ID_GUARD_BASE + 11'h03, 64'h0);
    check("rate kept", {60'h0, rate}, {60'h0, RATE_DFLT});
    for (int i = 0; i < 3; i++) begin
      dip <= sw[i] | 8'h21;
      power(7'h21);
      check("switch rate", {60'h0, rate}, {60'h0, rt[i]});
    end
    $display("switch test done");
    stop_test();
  end
endmodule
`default_nettype wire
